// file: verilog/hms_top.sv
// Overview of operation
// - rw signed 8-bit selector, resets zero
// - each accepted write forwarded to homing-mode parameter
// - save command stores written selector
// - power-up restores saved selector, overwrites parameter
// - code zero: no homing, position kept
// - codes 1,2: limit switch, then ref mark
// - codes 3,4: positive home switch, ref mark
// - codes 5,6: negative home switch, ref mark
// - codes 7-10: positive search, reverse, ref mark
// - codes 11-14: negative search, reverse, ref mark
// - codes 17,18: limit switch, no ref mark
// - codes 23-26: positive search, reverse, edge only
// - codes 27-30: negative search, reverse, edge only
// - codes 33,34: first ref mark neg/pos
// - code 35: load home offset as position
`include "hms_map.svh"
`timescale 1ns/1ps
`default_nettype none

module hms_top
  import hms_pkg::*;
#(
  parameter int POS_W = 32
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // object dictionary access
  input wire logic od_req_i,
  input wire logic od_wr_i,
  input wire logic [15:0] od_index_i,
  input wire logic [7:0] od_subidx_i,
  input wire logic [7:0] od_wdata_i,
  output logic od_ack_o,
  output logic od_abort_o,
  output logic [7:0] od_rdata_o,
  // drive parameter write
  output logic par_wr_o,
  output logic [15:0] par_num_o,
  output logic [7:0] par_data_o,
  // non-volatile store erase
  input wire logic nv_clear_i,
  // operating mode and command
  input wire logic motion_ctrl_i,
  input wire logic homing_mode_i,
  input wire logic home_start_i,
  // switches and encoder
  input wire logic lim_neg_i,
  input wire logic lim_pos_i,
  input wire logic home_sw_i,
  input wire logic ref_mark_i,
  input wire logic [POS_W-1:0] home_offset_i,
  // motion and result
  output logic drive_pos_o,
  output logic drive_neg_o,
  output logic creep_o,
  output logic busy_o,
  output logic done_o,
  output logic error_o,
  output logic pos_load_o,
  output logic [POS_W-1:0] pos_value_o
);

  // ----------------------------------------
  // method decoding
  // ----------------------------------------
  function automatic hms_dec_t hms_decode(input logic [7:0] m);
    hms_dec_t d;
    logic [7:0] b;
    logic [7:0] i;
    d.valid = 1'b1;
    d.kind = HMS_K_NONE;
    d.dir = 1'b0;
    d.use_ref = 1'b0;
    d.side = 1'b0;
    d.edge_r = 1'b0;
    b = m;
    i = 8'h00;
    if (m == `HMS_M_NONE) begin
      d.kind = HMS_K_NONE;
    end else if (m <= `HMS_M_LAST && m != `HMS_M_REF_LAST + 8'h01 &&
                 m != `HMS_M_NOREF_OFS) begin
      // upper half mirrors lower half without ref
      if (m > `HMS_M_NOREF_OFS) begin
        b = m - `HMS_M_NOREF_OFS;
      end
      d.use_ref = (m <= `HMS_M_REF_LAST);
      if (b <= `HMS_M_LIM_LAST) begin
        // limit target, ref search backs off
        d.kind = HMS_K_LIM;
        d.dir = (b == `HMS_M_LIM_LAST);
        d.side = ~d.dir;
      end else if (b <= `HMS_M_HSW_LAST) begin
        d.kind = HMS_K_HSW;
        d.dir = (b <= `HMS_M_HSW_POS_LAST);
        d.side = (b == `HMS_M_HSW_POS_LAST) || (b == `HMS_M_HSW_NEG_FIRST);
      end else begin
        d.kind = HMS_K_SCAN;
        i = b - `HMS_M_SCAN_FIRST;
        d.dir = ~i[2];
        d.side = i[2] ? ~i[0] : i[0];
        d.edge_r = i[2] ? ~i[1] : i[1];
      end
    end else if (m == `HMS_M_REF_NEG || m == `HMS_M_REF_POS) begin
      d.kind = HMS_K_REF;
      d.dir = (m == `HMS_M_REF_POS);
    end else if (m == `HMS_M_CUR) begin
      d.kind = HMS_K_CUR;
    end else begin
      d.valid = 1'b0;
    end
    return d;
  endfunction : hms_decode

  // ----------------------------------------
  // selector, dictionary and boot
  // ----------------------------------------
  hms_boot_t boot_r;
  hms_boot_t boot_nxt;
  logic [7:0] method_r;
  logic [7:0] method_nxt;
  logic dirty_r;
  logic dirty_nxt;
  logic ack_r;
  logic ack_nxt;
  logic abort_r;
  logic abort_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic par_wr_r;
  logic par_wr_nxt;
  logic [7:0] par_data_r;
  logic [7:0] par_data_nxt;
  logic nv_wr_r;
  logic nv_wr_nxt;
  logic [7:0] nv_rdata;
  logic nv_valid;
  logic hit_method;
  logic hit_save;
  hms_dec_t nv_dec;
  hms_dec_t wd_dec;

  hms_nvstore #(
    .DW(8)
  ) u_nv (
    .clk_i(ref_clk_i),
    .clear_i(nv_clear_i),
    .wr_i(nv_wr_r),
    .wdata_i(method_r),
    .rdata_o(nv_rdata),
    .valid_o(nv_valid)
  );

  assign hit_method = (od_index_i == `HMS_IDX_METHOD) && (od_subidx_i == `HMS_SUB_METHOD);
  assign hit_save = (od_index_i == `HMS_IDX_SAVE) && (od_subidx_i == `HMS_SUB_SAVE);
  assign nv_dec = hms_decode(nv_rdata);
  assign wd_dec = hms_decode(od_wdata_i);

  always_comb begin
    boot_nxt = boot_r;
    method_nxt = method_r;
    dirty_nxt = dirty_r;
    ack_nxt = 1'b0;
    abort_nxt = 1'b0;
    rdata_nxt = rdata_r;
    par_wr_nxt = 1'b0;
    par_data_nxt = par_data_r;
    nv_wr_nxt = 1'b0;
    case (boot_r)
      HMS_B_READ: begin
        boot_nxt = HMS_B_LOAD;
      end
      HMS_B_LOAD: begin
        boot_nxt = HMS_B_RUN;
        if (nv_valid && nv_dec.valid) begin
          method_nxt = nv_rdata;
          par_wr_nxt = 1'b1;
          par_data_nxt = nv_rdata;
        end
      end
      default: begin
      end
    endcase
    if (od_req_i) begin
      // requests during the boot restore are refused
      if (boot_r != HMS_B_RUN) begin
        abort_nxt = 1'b1;
      end else if (hit_method && !od_wr_i) begin
        rdata_nxt = method_r;
        ack_nxt = 1'b1;
      end else if (hit_method) begin
        if (wd_dec.valid) begin
          method_nxt = od_wdata_i;
          dirty_nxt = 1'b1;
          ack_nxt = 1'b1;
          par_wr_nxt = 1'b1;
          par_data_nxt = od_wdata_i;
        end else begin
          abort_nxt = 1'b1;
        end
      end else if (hit_save && od_wr_i) begin
        nv_wr_nxt = dirty_r;
        dirty_nxt = 1'b0;
        ack_nxt = 1'b1;
      end else begin
        abort_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      boot_r <= HMS_B_READ;
      method_r <= `HMS_METHOD_RST;
      dirty_r <= 1'b0;
      ack_r <= 1'b0;
      abort_r <= 1'b0;
      rdata_r <= 8'h00;
      par_wr_r <= 1'b0;
      par_data_r <= 8'h00;
      nv_wr_r <= 1'b0;
    end else begin
      boot_r <= boot_nxt;
      method_r <= method_nxt;
      dirty_r <= dirty_nxt;
      ack_r <= ack_nxt;
      abort_r <= abort_nxt;
      rdata_r <= rdata_nxt;
      par_wr_r <= par_wr_nxt;
      par_data_r <= par_data_nxt;
      nv_wr_r <= nv_wr_nxt;
    end
  end

  // ----------------------------------------
  // homing sequencer
  // ----------------------------------------
  hms_state_t st_r;
  hms_state_t st_nxt;
  hms_dec_t dec_r;
  hms_dec_t dec_nxt;
  logic dir_r;
  logic dir_nxt;
  logic rev_r;
  logic rev_nxt;
  logic sw_prev_r;
  logic load_r;
  logic load_nxt;
  logic [POS_W-1:0] pos_r;
  logic [POS_W-1:0] pos_nxt;
  logic lim_ahead;
  logic sw_rise;
  logic sw_fall;
  logic edge_hit;
  logic enabled;
  hms_dec_t dec_now;

  // only in homing mode of motion control
  assign enabled = motion_ctrl_i && homing_mode_i;
  assign dec_now = hms_decode(method_r);
  assign lim_ahead = dir_r ? lim_pos_i : lim_neg_i;
  assign sw_rise = home_sw_i && !sw_prev_r;
  assign sw_fall = !home_sw_i && sw_prev_r;
  // moving positive, a left edge rises; moving negative, it falls
  assign edge_hit = dir_r ? (dec_r.edge_r ? sw_fall : sw_rise)
                          : (dec_r.edge_r ? sw_rise : sw_fall);

  always_comb begin
    st_nxt = st_r;
    dec_nxt = dec_r;
    dir_nxt = dir_r;
    rev_nxt = rev_r;
    load_nxt = 1'b0;
    pos_nxt = pos_r;
    if (!enabled) begin
      if (st_r == HMS_S_SEEK || st_r == HMS_S_REFS) begin
        st_nxt = HMS_S_IDLE;
      end
    end else if (st_r != HMS_S_SEEK && st_r != HMS_S_REFS) begin
      if (home_start_i && boot_r == HMS_B_RUN) begin
        dec_nxt = dec_now;
        dir_nxt = dec_now.dir;
        rev_nxt = 1'b0;
        case (dec_now.kind)
          HMS_K_LIM, HMS_K_SCAN: begin
            st_nxt = HMS_S_SEEK;
          end
          HMS_K_HSW: begin
            // head toward the switch edge from either side
            dir_nxt = dec_now.dir ? !home_sw_i : home_sw_i;
            st_nxt = HMS_S_SEEK;
          end
          HMS_K_REF: begin
            st_nxt = HMS_S_REFS;
          end
          HMS_K_CUR: begin
            load_nxt = 1'b1;
            pos_nxt = home_offset_i;
            st_nxt = HMS_S_DONE;
          end
          default: begin
            st_nxt = HMS_S_DONE;
          end
        endcase
      end
    end else if (st_r == HMS_S_SEEK) begin
      case (dec_r.kind)
        HMS_K_LIM: begin
          if (lim_ahead) begin
            dir_nxt = dec_r.side;
            st_nxt = dec_r.use_ref ? HMS_S_REFS : HMS_S_DONE;
          end
        end
        HMS_K_HSW: begin
          if (home_sw_i != sw_prev_r) begin
            dir_nxt = dec_r.side;
            st_nxt = dec_r.use_ref ? HMS_S_REFS : HMS_S_DONE;
          end else if (lim_ahead) begin
            st_nxt = HMS_S_FAIL;
          end
        end
        default: begin
          if (edge_hit) begin
            dir_nxt = dec_r.side;
            st_nxt = dec_r.use_ref ? HMS_S_REFS : HMS_S_DONE;
          end else if (lim_ahead && rev_r) begin
            st_nxt = HMS_S_FAIL;
          end else if (lim_ahead) begin
            dir_nxt = !dir_r;
            rev_nxt = 1'b1;
          end
        end
      endcase
    end else begin
      // first ref mark ends the search
      if (ref_mark_i) begin
        st_nxt = HMS_S_DONE;
      end else if (lim_ahead) begin
        st_nxt = HMS_S_FAIL;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_r <= HMS_S_IDLE;
      dec_r <= '0;
      dir_r <= 1'b0;
      rev_r <= 1'b0;
      sw_prev_r <= 1'b0;
      load_r <= 1'b0;
      pos_r <= '0;
      drive_pos_o <= 1'b0;
      drive_neg_o <= 1'b0;
      creep_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      error_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      dec_r <= dec_nxt;
      dir_r <= dir_nxt;
      rev_r <= rev_nxt;
      sw_prev_r <= home_sw_i;
      load_r <= load_nxt;
      pos_r <= pos_nxt;
      drive_pos_o <= (st_nxt == HMS_S_SEEK || st_nxt == HMS_S_REFS) && dir_nxt;
      drive_neg_o <= (st_nxt == HMS_S_SEEK || st_nxt == HMS_S_REFS) && !dir_nxt;
      creep_o <= (st_nxt == HMS_S_REFS);
      busy_o <= (st_nxt == HMS_S_SEEK || st_nxt == HMS_S_REFS);
      done_o <= (st_nxt == HMS_S_DONE);
      error_o <= (st_nxt == HMS_S_FAIL);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign od_ack_o = ack_r;
  assign od_abort_o = abort_r;
  assign od_rdata_o = rdata_r;
  assign par_wr_o = par_wr_r;
  assign par_num_o = `HMS_PAR_MODE;
  assign par_data_o = par_data_r;
  assign pos_load_o = load_r;
  assign pos_value_o = pos_r;

endmodule : hms_top

`default_nettype wire

// file: verilog/hms_map.svh
`ifndef HMS_MAP_SVH
`define HMS_MAP_SVH

// ----------------------------------------
// object dictionary addresses
// ----------------------------------------
`define HMS_IDX_METHOD 16'h6098
`define HMS_SUB_METHOD 8'h00
`define HMS_IDX_SAVE 16'h1010
`define HMS_SUB_SAVE 8'h01
`define HMS_PAR_MODE 16'h046a
`define HMS_METHOD_RST 8'h00

// ----------------------------------------
// method code boundaries
// ----------------------------------------
`define HMS_M_NONE 8'h00
`define HMS_M_LIM_LAST 8'h02
`define HMS_M_HSW_POS_LAST 8'h04
`define HMS_M_HSW_NEG_FIRST 8'h05
`define HMS_M_HSW_LAST 8'h06
`define HMS_M_SCAN_FIRST 8'h07
`define HMS_M_REF_LAST 8'h0e
`define HMS_M_NOREF_OFS 8'h10
`define HMS_M_LAST 8'h1e
`define HMS_M_REF_NEG 8'h21
`define HMS_M_REF_POS 8'h22
`define HMS_M_CUR 8'h23

`endif

// file: verilog/hms_pkg.sv
`include "hms_map.svh"

package hms_pkg;

  typedef enum logic [2:0] {
    HMS_K_NONE = 3'h0,
    HMS_K_LIM = 3'h1,
    HMS_K_HSW = 3'h2,
    HMS_K_SCAN = 3'h3,
    HMS_K_REF = 3'h4,
    HMS_K_CUR = 3'h5
  } hms_kind_t;

  typedef struct packed {
    logic valid;
    hms_kind_t kind;
    logic dir;
    logic use_ref;
    logic side;
    logic edge_r;
  } hms_dec_t;

  typedef enum logic [2:0] {
    HMS_S_IDLE = 3'b000,
    HMS_S_SEEK = 3'b001,
    HMS_S_REFS = 3'b011,
    HMS_S_DONE = 3'b010,
    HMS_S_FAIL = 3'b110
  } hms_state_t;

  typedef enum logic [1:0] {
    HMS_B_READ = 2'b00,
    HMS_B_LOAD = 2'b01,
    HMS_B_RUN = 2'b11
  } hms_boot_t;

endpackage : hms_pkg

// file: verilog/hms_nvstore.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// non-volatile selector store
// ----------------------------------------
// no reset on purpose: contents must survive rst_i like a power cycle
module hms_nvstore #(
  parameter int DW = 8
) (
  // clock
  input wire logic clk_i,
  // erase of the store
  input wire logic clear_i,
  // write port
  input wire logic wr_i,
  input wire logic [DW-1:0] wdata_i,
  // read port
  output logic [DW-1:0] rdata_o,
  output logic valid_o
);

  logic [DW-1:0] mem_r;
  logic [DW-1:0] mem_nxt;
  logic valid_r;
  logic valid_nxt;
  logic [DW-1:0] rd_r;

  always_comb begin
    mem_nxt = mem_r;
    valid_nxt = valid_r;
    // a save landing with an erase wins, so a fresh value is never lost
    if (wr_i) begin
      mem_nxt = wdata_i;
      valid_nxt = 1'b1;
    end else if (clear_i) begin
      valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    mem_r <= mem_nxt;
    valid_r <= valid_nxt;
    rd_r <= mem_r;
  end

  assign rdata_o = rd_r;
  assign valid_o = valid_r;

endmodule : hms_nvstore

`default_nettype wire

// file: verification/hms_master.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// dictionary master model
// ----------------------------------------
module hms_master (
  // clock
  input wire logic clk_i,
  // request lines
  output logic req_o,
  output logic wr_o,
  output logic [15:0] index_o,
  output logic [7:0] subidx_o,
  output logic [7:0] wdata_o
);
  initial begin
    req_o = 1'b0;
    wr_o = 1'b0;
    index_o = 16'h0000;
    subidx_o = 8'h00;
    wdata_o = 8'h00;
  end

  // each high cycle is a new request, so the strobe lasts one cycle only
  task automatic xfer(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                      input logic [7:0] d);
    @(posedge clk_i);
    #1 req_o = 1'b1;
    wr_o = w;
    index_o = ix;
    subidx_o = sb;
    wdata_o = d;
    @(posedge clk_i);
    #1 req_o = 1'b0;
    // released lines carry junk, never the last value
    wr_o = ~wr_o;
    index_o = ~index_o;
    subidx_o = ~subidx_o;
    wdata_o = ~wdata_o;
  endtask : xfer
endmodule : hms_master

`default_nettype wire

// file: verification/hms_props.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// selector and homing checks
// ----------------------------------------
module hms_props #(
  parameter int POS_W = 32
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // dictionary
  input wire logic od_req_i,
  input wire logic od_wr_i,
  input wire logic [15:0] od_index_i,
  input wire logic [7:0] od_subidx_i,
  input wire logic [7:0] od_wdata_i,
  input wire logic od_ack_o,
  input wire logic od_abort_o,
  input wire logic par_wr_o,
  input wire logic [15:0] par_num_o,
  input wire logic [7:0] par_data_o,
  // homing
  input wire logic motion_ctrl_i,
  input wire logic homing_mode_i,
  input wire logic home_start_i,
  input wire logic lim_neg_i,
  input wire logic lim_pos_i,
  input wire logic ref_mark_i,
  input wire logic [POS_W-1:0] home_offset_i,
  input wire logic drive_pos_o,
  input wire logic drive_neg_o,
  input wire logic creep_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic pos_load_o,
  input wire logic [POS_W-1:0] pos_value_o
);
  logic [2:0] up_r, up_nxt;
  logic go, wr_sel, bad, pos_c, neg_c;

  // starts are only judged once boot is surely over
  always_comb begin
    up_nxt = rst_i ? 3'h0 : (up_r == 3'h4) ? up_r : up_r + 3'h1;
  end
  always_ff @(posedge ref_clk_i) begin
    up_r <= up_nxt;
  end

  assign go = home_start_i && motion_ctrl_i && homing_mode_i && !busy_o && up_r == 3'h4;
  assign wr_sel = od_req_i && od_wr_i && od_index_i == 16'h6098 && od_subidx_i == 8'h00;
  assign bad = od_wdata_i[7] || od_wdata_i > 8'h23 || od_wdata_i inside {8'h0f, 8'h10, 8'h1f, 8'h20};
  assign pos_c = par_data_o inside {8'h02, [8'h07:8'h0a], 8'h12, [8'h17:8'h1a], 8'h22};
  assign neg_c = par_data_o inside {8'h01, [8'h0b:8'h0e], 8'h11, [8'h1b:8'h1e], 8'h21};

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  answer_once_a: assert property (od_req_i |=> od_ack_o != od_abort_o)
    else $error("request not answered exactly once");
  no_stray_a: assert property ((od_ack_o || od_abort_o) |-> $past(od_req_i))
    else $error("answer without request");
  par_copy_a: assert property (wr_sel ##1 od_ack_o |->
    par_wr_o && par_data_o == $past(od_wdata_i))
    else $error("selector write not copied");
  par_num_a: assert property (par_wr_o |-> par_num_o == 16'h046a)
    else $error("wrong parameter number");
  bad_code_a: assert property (wr_sel && bad |=> od_abort_o && !par_wr_o)
    else $error("unassigned code accepted");
  code_zero_a: assert property (go && par_data_o == 8'h00 |=> done_o && !busy_o)
    else $error("code zero moved");
  code_cur_a: assert property (go && par_data_o == 8'h23 |=>
    done_o && pos_load_o && pos_value_o == $past(home_offset_i))
    else $error("offset not loaded");
  start_pos_a: assert property (go && pos_c |=> busy_o && drive_pos_o)
    else $error("no positive start");
  start_neg_a: assert property (go && neg_c |=> busy_o && drive_neg_o)
    else $error("no negative start");
  mode_drop_a: assert property (busy_o && !(homing_mode_i && motion_ctrl_i) |=>
    !busy_o && !drive_pos_o && !drive_neg_o && !done_o)
    else $error("motion kept outside homing mode");
  ref_hit_a: assert property (creep_o && ref_mark_i && homing_mode_i && motion_ctrl_i &&
    !lim_neg_i && !lim_pos_i |=> done_o && !busy_o && !creep_o)
    else $error("ref mark did not end homing");
endmodule : hms_props

bind hms_top hms_props #(.POS_W(POS_W)) hms_props_i (.*);

`default_nettype wire

// file: verification/hms_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// homing selector bench
// ----------------------------------------
module hms_top_bench;
  import hms_pkg::*;
  localparam int PW = 32;
  logic ref_clk_i = 1'b0, rst_i, nv_clear_i = 1'b1, motion_ctrl_i = 1'b1;
  logic homing_mode_i = 1'b1, home_start_i = 1'b0, lim_neg_i = 1'b0, lim_pos_i = 1'b0;
  logic home_sw_i = 1'b0, ref_mark_i = 1'b0, pd, hd;
  logic [PW-1:0] home_offset_i = 32'h0000_0000, pos_value_o;
  logic od_req_i, od_wr_i, od_ack_o, od_abort_o, par_wr_o, drive_pos_o, drive_neg_o;
  logic creep_o, busy_o, done_o, error_o, pos_load_o;
  logic [15:0] od_index_i, par_num_o;
  logic [7:0] od_subidx_i, od_wdata_i, od_rdata_o, par_data_o, sel;
  logic [7:0] dl[10] = '{8'h01, 8'h02, 8'h07, 8'h0b, 8'h11, 8'h12, 8'h17, 8'h1b, 8'h21, 8'h22};
  logic [10:0] oq[$];
  logic [10:0] e;
  logic [1:0] hq[$];
  int err_total = 0, compares = 0;

  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  hms_master hms_master_i (.clk_i(ref_clk_i), .req_o(od_req_i), .wr_o(od_wr_i),
    .index_o(od_index_i), .subidx_o(od_subidx_i), .wdata_o(od_wdata_i));
  hms_top #(.POS_W(PW)) hms_top_i (.ref_clk_i, .rst_i, .od_req_i, .od_wr_i, .od_index_i,
    .od_subidx_i, .od_wdata_i, .od_ack_o, .od_abort_o, .od_rdata_o, .par_wr_o, .par_num_o,
    .par_data_o, .nv_clear_i, .motion_ctrl_i, .homing_mode_i, .home_start_i, .lim_neg_i,
    .lim_pos_i, .home_sw_i, .ref_mark_i, .home_offset_i, .drive_pos_o, .drive_neg_o,
    .creep_o, .busy_o, .done_o, .error_o, .pos_load_o, .pos_value_o);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    if (oq.size() != 0 || hq.size() != 0) err_total++;
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // kind: 0 plain, 1 read data, 2 parameter copy
  task automatic sdo(input logic [1:0] k, input logic w, input logic [15:0] ix,
                     input logic [7:0] sb, input logic [7:0] d, input logic ab,
                     input logic [7:0] x);
    oq.push_back({k, ab, x});
    hms_master_i.xfer(w, ix, sb, d);
  endtask : sdo

  task automatic wm(input logic [7:0] c);
    logic bad;
    bad = c[7] || c > 8'h23 || c inside {8'h0f, 8'h10, 8'h1f, 8'h20};
    if (!bad) sel = c;
    sdo(2'h2, 1'b1, 16'h6098, 8'h00, c, bad, c);
  endtask : wm

  task automatic rd(input logic [7:0] x);
    sdo(2'h1, 1'b0, 16'h6098, 8'h00, 8'h00, 1'b0, x);
  endtask : rd

  task automatic pulse(ref logic s);
    @(posedge ref_clk_i);
    #1 s = 1'b1;
    @(posedge ref_clk_i);
    #1 s = 1'b0;
  endtask : pulse

  task automatic do_reset;
    rst_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    // boot still running, so this one is refused
    sdo(2'h0, 1'b0, 16'h6098, 8'h00, 8'h00, 1'b1, 8'h00);
  endtask : do_reset

  always @(posedge ref_clk_i) begin
    if (!rst_i && (od_ack_o || od_abort_o)) begin
      chk(oq.size() != 0, 1'b1);
      e = oq.pop_front();
      chk(od_abort_o, e[8]);
      if (e[10:9] == 2'h1) chk(od_rdata_o, e[7:0]);
      if (od_ack_o && e[10:9] == 2'h2) chk({par_wr_o, par_data_o}, {1'b1, e[7:0]});
    end
    if (!rst_i && ((done_o || error_o) && !hd || pos_load_o)) begin
      chk({error_o, pos_load_o}, hq.size() != 0 ? hq.pop_front() : 2'h3);
    end
    hd = done_o || error_o;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    chk(32'h0, 32'h1);
    report_and_stop();
  end

  initial begin
    void'($urandom(60632));
    sel = 8'h00;
    do_reset();
    nv_clear_i = 1'b0;
    rd(8'h00);
    for (int c = 0; c < 40; c++) begin
      wm(c[7:0]);
      rd(sel);
    end
    wm({1'b1, 7'($urandom)});
    rd(sel);
    sdo(2'h0, 1'b1, 16'h6097, 8'h00, 8'h01, 1'b1, 8'h00);
    sdo(2'h0, 1'b0, 16'h1010, 8'h01, 8'h00, 1'b1, 8'h00);
    // saved value must beat the later unsaved one
    wm(8'h05);
    sdo(2'h0, 1'b1, 16'h1010, 8'h01, 8'h00, 1'b0, 8'h00);
    wm(8'h09);
    // let the last answer be checked before reset clears it
    @(posedge ref_clk_i);
    #1 do_reset();
    rd(8'h05);
    chk(par_data_o, 8'h05);
    foreach (dl[i]) begin
      wm(dl[i]);
      pd = dl[i] inside {8'h02, 8'h07, 8'h12, 8'h17, 8'h22};
      pulse(home_start_i);
      chk({busy_o, drive_pos_o, drive_neg_o}, {1'b1, pd, !pd});
      homing_mode_i = 1'b0;
      @(posedge ref_clk_i);
      #1 chk({busy_o, drive_pos_o, drive_neg_o, done_o}, 4'h0);
      homing_mode_i = 1'b1;
    end
    wm(8'h00);
    hq.push_back(2'h0);
    pulse(home_start_i);
    chk({busy_o, done_o}, 2'h1);
    wm(8'h02);
    hq.push_back(2'h0);
    pulse(home_start_i);
    pulse(lim_pos_i);
    chk({busy_o, drive_pos_o, drive_neg_o, creep_o}, 4'hb);
    pulse(ref_mark_i);
    wm(8'h12);
    hq.push_back(2'h0);
    pulse(home_start_i);
    pulse(lim_pos_i);
    chk({busy_o, creep_o, done_o}, 3'h1);
    wm(8'h03);
    hq.push_back(2'h0);
    pulse(home_start_i);
    pulse(home_sw_i);
    chk({busy_o, drive_pos_o, drive_neg_o, creep_o}, 4'hb);
    pulse(ref_mark_i);
    wm(8'h13);
    hq.push_back(2'h0);
    pulse(home_start_i);
    pulse(home_sw_i);
    chk({busy_o, creep_o, done_o}, 3'h1);
    wm(8'h17);
    hq.push_back(2'h2);
    pulse(home_start_i);
    pulse(lim_pos_i);
    chk({busy_o, drive_pos_o, drive_neg_o}, 3'h5);
    pulse(lim_neg_i);
    chk({busy_o, error_o}, 2'h1);
    home_offset_i = $urandom;
    wm(8'h23);
    hq.push_back(2'h1);
    pulse(home_start_i);
    chk(pos_value_o, home_offset_i);
    repeat (2) @(posedge ref_clk_i);
    report_and_stop();
  end
endmodule : hms_top_bench

`default_nettype wire
